// file: core/sfxip_regs.svh
// constants for the serial flash xip and power-up control block
`ifndef SFXIP_REGS_SVH
`define SFXIP_REGS_SVH
`define SFXIP_VCR_XIP_BIT 3
`define SFXIP_NVCR_XIP_MSB 11
`define SFXIP_NVCR_XIP_LSB 9
`define SFXIP_NVCR_XIP_OFF 3'h7
`define SFXIP_CLK_NS 40
`define SFXIP_PWR_READ_US 150
`define SFXIP_PWR_CYC ((`SFXIP_PWR_READ_US * 1000) / `SFXIP_CLK_NS)
`define SFXIP_EXIT_QUAD 7
`define SFXIP_EXIT_DUAL 13
`define SFXIP_EXIT_EXT 25
`define SFXIP_FF_CLKS 8
`define SFXIP_CMD_FAST_READ 8'h0b
`define SFXIP_CMD_RD_STATUS 8'h05
`define SFXIP_CMD_RD_FLAG 8'h70
`define SFXIP_CMD_WREN 8'h06
`define SFXIP_CMD_WRDI 8'h04
`define SFXIP_DUMMY_CLKS 8
`endif

// file: core/sfxip_pkg.sv
// types for the serial flash xip and power-up control block
package sfxip_pkg;
    typedef enum logic [1:0] {
        SFXIP_PROTO_EXT = 2'h0,
        SFXIP_PROTO_DUAL = 2'h1,
        SFXIP_PROTO_QUAD = 2'h3
    } sfxip_proto_t;
    typedef enum logic [2:0] {
        SFXIP_ST_IDLE = 3'h0,
        SFXIP_ST_CMD = 3'h1,
        SFXIP_ST_ADDR = 3'h3,
        SFXIP_ST_DUMMY = 3'h2,
        SFXIP_ST_DATA = 3'h6,
        SFXIP_ST_DONE = 3'h7
    } sfxip_state_t;
endpackage

// file: core/sfxip_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module sfxip_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_r[i] <= d[i];
                    q[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// file: core/sfxip_powerup.sv
// power-up window counter
`timescale 1ns/1ps
`include "sfxip_regs.svh"
module sfxip_powerup #(
    parameter int PWR_CYC = `SFXIP_PWR_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    output logic busy
);
    logic [16:0] cnt_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 17'h0;
            busy <= 1'b1;
        end else if (busy) begin
            if (cnt_r == 17'(PWR_CYC - 1)) begin
                busy <= 1'b0;
            end
            cnt_r <= cnt_r + 17'h1;
        end
    end
endmodule

// file: core/sfxip_core.sv
// xip entry/exit, power-up gating and rescue logic of the serial flash
`timescale 1ns/1ps
`include "sfxip_regs.svh"
module sfxip_core
    import sfxip_pkg::*;
#(
    parameter int PWR_CYC = `SFXIP_PWR_CYC
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic reset_n,
    // serial pins
    input wire logic chip_sel_n,
    input wire logic serial_clk,
    input wire logic serial_io_line0,
    input wire logic serial_io_line1,
    input wire logic serial_io_line2,
    input wire logic serial_io_line3_hold,
    input wire logic dev_reset_pin_n,
    // straps and configuration
    input wire logic basic_xip_variant,
    input wire logic reset_pin_enable,
    input wire logic [2:0] nvcr_xip_sel,
    input wire logic [1:0] nvcr_proto,
    input wire logic wip_ext,
    // status
    output logic xip_active,
    output logic vcr_xip_bit,
    output sfxip_proto_t proto,
    output logic powerup_busy,
    output logic wel,
    output logic wip,
    output logic lock_write,
    output logic lock_down,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic cmd_rejected,
    output logic addr_valid,
    output logic [23:0] addr,
    output logic rescue_done
);
    logic [6:0] sy;
    logic cs_n_s, sck_s, io0_s, io1_s, io2_s, io3_s, rstp_n_s;
    logic cs_sel_s, rst_low_s;
    logic sck_d_r, cs_d_r, rst_d_r;
    logic rise, cs_fall, cs_rise, rst_pulse;
    sfxip_state_t st_r;
    logic [4:0] bit_r;
    logic [7:0] sh_cmd_r;
    logic [23:0] sh_addr_r;
    logic [4:0] sel_clks_r;
    logic all_ones_r;
    logic hold_ones_r;
    logic [7:0] pu_cmd_r;
    logic [1:0] resc_r;
    logic dummy_first_r;
    logic [2:0] nv_sel_r;
    logic [1:0] nv_proto_r;
    logic [4:0] addr_clks;
    logic [2:0] step;
    logic nv_xip;

    sfxip_sync #(.W(7)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d({~chip_sel_n, serial_clk, serial_io_line0, serial_io_line1,
            serial_io_line2, serial_io_line3_hold, ~dev_reset_pin_n}),
        .q(sy)
    );
    assign {cs_sel_s, sck_s, io0_s, io1_s, io2_s, io3_s, rst_low_s} = sy;
    // active-low pins enter inverted so a cleared stage reads as idle
    assign cs_n_s = ~cs_sel_s;
    assign rstp_n_s = ~rst_low_s;

    // holds the decoder, rescue and write-latch logic in reset until the window ends; pin sampling and the status-read check keep running
    sfxip_powerup #(.PWR_CYC(PWR_CYC)) u_pwr (
        .clk(clk),
        .reset_n(reset_n),
        .busy(powerup_busy)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            rst_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            cs_d_r <= cs_n_s;
            rst_d_r <= rstp_n_s;
        end
    end
    assign rise = sck_s & ~sck_d_r & ~cs_n_s;
    assign cs_fall = cs_d_r & ~cs_n_s;
    assign cs_rise = ~cs_d_r & cs_n_s;
    // rising edge of pin ends the pulse; acted on only when deselected
    assign rst_pulse = reset_pin_enable & rstp_n_s & ~rst_d_r
        & cs_n_s;

    // config sampled through the power-up window, held after it ends
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nv_sel_r <= `SFXIP_NVCR_XIP_OFF;
            nv_proto_r <= 2'h0;
        end else if (powerup_busy) begin
            nv_sel_r <= nvcr_xip_sel;
            nv_proto_r <= nvcr_proto;
        end
    end
    assign nv_xip = nv_sel_r != `SFXIP_NVCR_XIP_OFF;

    always_comb begin
        step = 3'h1;
        addr_clks = 5'd24;
        unique case (proto)
            SFXIP_PROTO_DUAL: begin
                step = 3'h2;
                addr_clks = 5'd12;
            end
            SFXIP_PROTO_QUAD: begin
                step = 3'h4;
                addr_clks = 5'd6;
            end
            default: begin
                step = 3'h1;
                addr_clks = 5'd24;
            end
        endcase
    end

    // clocks per selection with line 0 (and 3 for rescue) held high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_clks_r <= 5'h0;
            all_ones_r <= 1'b1;
            hold_ones_r <= 1'b1;
            pu_cmd_r <= 8'h0;
        end else if (cs_fall) begin
            sel_clks_r <= 5'h0;
            all_ones_r <= 1'b1;
            hold_ones_r <= 1'b1;
            pu_cmd_r <= 8'h0;
        end else if (rise) begin
            if (sel_clks_r != 5'h1f) begin
                sel_clks_r <= sel_clks_r + 5'h1;
            end
            all_ones_r <= all_ones_r & io0_s;
            // line 3 judged while clocked, not after the host lets go
            hold_ones_r <= hold_ones_r & io3_s;
            pu_cmd_r <= {pu_cmd_r[6:0], io0_s};
        end
    end

    // transaction decoder
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= SFXIP_ST_IDLE;
            bit_r <= 5'h0;
            sh_cmd_r <= 8'h0;
            sh_addr_r <= 24'h0;
            dummy_first_r <= 1'b0;
        end else if (cs_n_s || powerup_busy) begin
            st_r <= SFXIP_ST_IDLE;
            bit_r <= 5'h0;
        end else if (st_r == SFXIP_ST_IDLE) begin
            st_r <= xip_active ? SFXIP_ST_ADDR : SFXIP_ST_CMD;
            bit_r <= 5'h0;
            dummy_first_r <= 1'b1;
        end else if (rise) begin
            unique case (st_r)
                SFXIP_ST_CMD: begin
                    sh_cmd_r <= {sh_cmd_r[6:0], io0_s};
                    bit_r <= bit_r + 5'h1;
                    if (bit_r == 5'd7) begin
                        bit_r <= 5'h0;
                        st_r <= ({sh_cmd_r[6:0], io0_s}
                            == `SFXIP_CMD_FAST_READ)
                            ? SFXIP_ST_ADDR : SFXIP_ST_DONE;
                    end
                end
                SFXIP_ST_ADDR: begin
                    unique case (step)
                        3'h2: sh_addr_r <= {sh_addr_r[21:0], io1_s, io0_s};
                        3'h4: sh_addr_r <= {sh_addr_r[19:0], io3_s, io2_s,
                            io1_s, io0_s};
                        default: sh_addr_r <= {sh_addr_r[22:0], io0_s};
                    endcase
                    bit_r <= bit_r + 5'h1;
                    if (bit_r == addr_clks - 5'h1) begin
                        bit_r <= 5'h0;
                        st_r <= SFXIP_ST_DUMMY;
                    end
                end
                SFXIP_ST_DUMMY: begin
                    dummy_first_r <= 1'b0;
                    bit_r <= bit_r + 5'h1;
                    if (bit_r == 5'(`SFXIP_DUMMY_CLKS - 1)) begin
                        st_r <= SFXIP_ST_DATA;
                    end
                end
                default: st_r <= st_r;
            endcase
        end
    end

    // fast read presents the confirmation bit on line 0 only
    logic confirm_now, xip_confirm_bit;
    assign confirm_now = rise && st_r == SFXIP_ST_DUMMY
        && dummy_first_r;
    assign xip_confirm_bit = io0_s;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_valid <= 1'b0;
            addr <= 24'h0;
            cmd_valid <= 1'b0;
            cmd_code <= 8'h0;
            cmd_rejected <= 1'b0;
        end else begin
            addr_valid <= confirm_now;
            cmd_valid <= 1'b0;
            cmd_rejected <= 1'b0;
            if (confirm_now) begin
                addr <= sh_addr_r;
            end
            if (rise && st_r == SFXIP_ST_CMD && bit_r == 5'd7) begin
                cmd_code <= {sh_cmd_r[6:0], io0_s};
                cmd_valid <= 1'b1;
            end
            // only the two status reads pass during the power-up window
            if (powerup_busy && rise && sel_clks_r == 5'h7
                && {pu_cmd_r[6:0], io0_s} != `SFXIP_CMD_RD_STATUS
                && {pu_cmd_r[6:0], io0_s} != `SFXIP_CMD_RD_FLAG) begin
                cmd_rejected <= 1'b1;
            end
        end
    end

    // xip flag and volatile xip bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xip_active <= 1'b0;
            vcr_xip_bit <= 1'b1;
        end else if (powerup_busy) begin
            xip_active <= nv_xip;
            vcr_xip_bit <= ~nv_xip;
        end else if (rst_pulse) begin
            xip_active <= nv_xip;
            vcr_xip_bit <= ~nv_xip;
        end else if (cs_rise && all_ones_r && xip_active
            && sel_clks_r != 5'h0 && sel_clks_r
            < (proto == SFXIP_PROTO_QUAD ? 5'(`SFXIP_EXIT_QUAD + 1)
            : proto == SFXIP_PROTO_DUAL ? 5'(`SFXIP_EXIT_DUAL + 1)
            : 5'(`SFXIP_EXIT_EXT + 1))) begin
            // aborted select counts as confirmation one; wip untouched
            xip_active <= 1'b0;
            vcr_xip_bit <= 1'b1;
        end else if (resc_r == 2'h3 && cs_rise && all_ones_r
            && hold_ones_r && sel_clks_r == 5'(`SFXIP_FF_CLKS)) begin
            xip_active <= 1'b0;
            vcr_xip_bit <= 1'b1;
        end else if (confirm_now) begin
            if (xip_confirm_bit) begin
                xip_active <= 1'b0;
                vcr_xip_bit <= 1'b1;
            end else if (!vcr_xip_bit || basic_xip_variant
                || xip_active) begin
                xip_active <= 1'b1;
            end
        end
    end

    // rescue: 7, 13, 25 then ff; protocol falls back to extended
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resc_r <= 2'h0;
            proto <= SFXIP_PROTO_EXT;
        end else if (powerup_busy || rst_pulse) begin
            resc_r <= 2'h0;
            proto <= sfxip_proto_t'(nv_proto_r == 2'h2 ? 2'h0 : nv_proto_r);
        end else if (cs_rise) begin
            if (all_ones_r && hold_ones_r) begin
                unique case (resc_r)
                    2'h0: resc_r <= (sel_clks_r == 5'(`SFXIP_EXIT_QUAD))
                        ? 2'h1 : 2'h0;
                    2'h1: resc_r <= (sel_clks_r == 5'(`SFXIP_EXIT_DUAL))
                        ? 2'h2 : 2'h0;
                    2'h2: resc_r <= (sel_clks_r == 5'(`SFXIP_EXIT_EXT))
                        ? 2'h3 : 2'h0;
                    default: begin
                        resc_r <= 2'h0;
                        if (sel_clks_r == 5'(`SFXIP_FF_CLKS)) begin
                            proto <= SFXIP_PROTO_EXT;
                        end
                    end
                endcase
            end else begin
                resc_r <= 2'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rescue_done <= 1'b0;
        end else begin
            rescue_done <= resc_r == 2'h3 && cs_rise && all_ones_r
                && hold_ones_r && sel_clks_r == 5'(`SFXIP_FF_CLKS);
        end
    end

    // write latches: cleared through power-up, no program engine here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wel <= 1'b0;
            wip <= 1'b0;
            lock_write <= 1'b0;
            lock_down <= 1'b0;
        end else if (powerup_busy) begin
            wel <= 1'b0;
            wip <= 1'b0;
        end else begin
            wip <= wip_ext;
            if (cmd_valid && cmd_code == `SFXIP_CMD_WREN) begin
                wel <= 1'b1;
            end else if (cmd_valid && cmd_code == `SFXIP_CMD_WRDI) begin
                wel <= 1'b0;
            end
        end
    end
endmodule

// file: testbench/sfxip_core_props.sv
// assertions on the xip and power-up control block
`timescale 1ns/1ps
module sfxip_core_props
    import sfxip_pkg::*;
#(
    parameter int PWR_CYC = 3750
) (
    // clock, reset and straps
    input wire logic clk,
    input wire logic reset_n,
    input wire logic basic_xip_variant,
    input wire logic reset_pin_enable,
    input wire logic [2:0] nvcr_xip_sel,
    // pins
    input wire logic chip_sel_n,
    input wire logic dev_reset_pin_n,
    // status
    input wire logic xip_active,
    input wire logic vcr_xip_bit,
    input wire sfxip_proto_t proto,
    input wire logic powerup_busy,
    input wire logic wel,
    input wire logic lock_write,
    input wire logic lock_down,
    input wire logic cmd_valid,
    input wire logic cmd_rejected,
    input wire logic addr_valid,
    input wire logic rescue_done
);
    logic [15:0] busy_cnt_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_r <= 16'h0;
        end else if (powerup_busy) begin
            busy_cnt_r <= busy_cnt_r + 16'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_ext_plain;
        proto == SFXIP_PROTO_EXT && !xip_active;
    endsequence
    sequence s_pin_release;
        $rose(dev_reset_pin_n) && reset_pin_enable && chip_sel_n;
    endsequence
    a_busy_no_decode: assert property (
        powerup_busy |-> !cmd_valid && !addr_valid)
        else $error("decode during power-up");
    a_reject_in_busy: assert property (
        cmd_rejected |-> powerup_busy || $past(powerup_busy))
        else $error("reject outside power-up");
    a_busy_length: assert property (
        $fell(powerup_busy) |->
        busy_cnt_r >= PWR_CYC - 1 && busy_cnt_r <= PWR_CYC + 1)
        else $error("power-up window length wrong");
    a_boot_xip: assert property (
        $fell(powerup_busy) |-> xip_active == (nvcr_xip_sel != 3'h7))
        else $error("boot xip state wrong");
    a_boot_clear: assert property (
        $fell(powerup_busy) |-> !wel && !lock_write && !lock_down)
        else $error("latches not clear after power-up");
    a_vcr_restore: assert property (
        $fell(xip_active) |-> ##[0:2] vcr_xip_bit)
        else $error("config bit not restored on exit");
    a_enter_dummy: assert property (
        $rose(xip_active) && !powerup_busy && nvcr_xip_sel == 3'h7
        |-> addr_valid || $past(addr_valid))
        else $error("xip entered outside dummy clock");
    a_vcr_gate: assert property (
        $rose(addr_valid) && !$past(xip_active) && vcr_xip_bit &&
        !basic_xip_variant |-> !xip_active [*3])
        else $error("xip entered while not enabled");
    a_pin_clears: assert property (
        s_pin_release ##0 nvcr_xip_sel == 3'h7 |-> ##[1:6] !xip_active)
        else $error("reset pin did not clear xip");
    a_rescue_ext: assert property (
        rescue_done |-> ##[0:1] s_ext_plain)
        else $error("rescue did not restore extended mode");
endmodule
bind sfxip_core sfxip_core_props #(.PWR_CYC(PWR_CYC)) sfxip_core_props_inst (
    .clk(clk), .reset_n(reset_n), .basic_xip_variant(basic_xip_variant),
    .reset_pin_enable(reset_pin_enable), .nvcr_xip_sel(nvcr_xip_sel),
    .chip_sel_n(chip_sel_n), .dev_reset_pin_n(dev_reset_pin_n),
    .xip_active(xip_active), .vcr_xip_bit(vcr_xip_bit), .proto(proto),
    .powerup_busy(powerup_busy), .wel(wel), .lock_write(lock_write),
    .lock_down(lock_down), .cmd_valid(cmd_valid),
    .cmd_rejected(cmd_rejected), .addr_valid(addr_valid),
    .rescue_done(rescue_done)
);

// file: testbench/sfxip_host.sv
// spi host controller model driving the flash pins
`timescale 1ns/1ps
module sfxip_host (
    // system clock
    input wire logic clk,
    // pins towards the flash
    output logic chip_sel_n,
    output logic serial_clk,
    output logic [3:0] io_lines
);
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
        io_lines = 4'h5;
    end
    // one selection, one nibble per link clock, data set while clock low
    task automatic frame(input logic [3:0] nib[$]);
        @(posedge clk);
        chip_sel_n <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (nib[i]) begin
            io_lines <= nib[i];
            repeat (4) @(posedge clk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge clk);
            serial_clk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        chip_sel_n <= 1'b1;
        // released lines must not keep showing the last value
        io_lines <= ~io_lines;
        repeat (4) @(posedge clk);
    endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the xip and power-up control block
`timescale 1ns/1ps
`include "sfxip_regs.svh"
module tb_top
    import sfxip_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic dev_reset_pin_n = 1'b1;
    logic basic_xip_variant = 1'b0;
    logic reset_pin_enable = 1'b0;
    logic [2:0] nvcr_xip_sel = 3'h7;
    logic [1:0] nvcr_proto = 2'h0;
    logic wip_ext = 1'b0;
    logic chip_sel_n, serial_clk, xip_active, vcr_xip_bit, powerup_busy;
    logic wel, wip, lock_write, lock_down, cmd_valid, cmd_rejected;
    logic addr_valid, rescue_done;
    logic [3:0] io;
    logic [7:0] cmd_code;
    logic [23:0] addr;
    sfxip_proto_t proto;
    logic [3:0] q[$];
    logic [23:0] exp_q[$];
    int n[3] = '{7, 13, 25};
    int w[3] = '{4, 2, 1};
    logic [1:0] n_rej = 2'h0;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    bit watch = 1'b1;
    bit rescue_seen = 1'b0;
    always #20 clk = ~clk;
    sfxip_host sfxip_host_inst (.clk(clk), .chip_sel_n(chip_sel_n),
        .serial_clk(serial_clk), .io_lines(io));
    // window long enough to fit two command frames inside it
    sfxip_core #(.PWR_CYC(240)) sfxip_core_inst (
        .clk(clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n),
        .serial_clk(serial_clk), .serial_io_line0(io[0]),
        .serial_io_line1(io[1]), .serial_io_line2(io[2]),
        .serial_io_line3_hold(io[3]), .dev_reset_pin_n(dev_reset_pin_n),
        .basic_xip_variant(basic_xip_variant),
        .reset_pin_enable(reset_pin_enable), .nvcr_xip_sel(nvcr_xip_sel),
        .nvcr_proto(nvcr_proto), .wip_ext(wip_ext),
        .xip_active(xip_active), .vcr_xip_bit(vcr_xip_bit), .proto(proto),
        .powerup_busy(powerup_busy), .wel(wel), .wip(wip),
        .lock_write(lock_write), .lock_down(lock_down),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_rejected(cmd_rejected), .addr_valid(addr_valid), .addr(addr),
        .rescue_done(rescue_done));
    task automatic check(input string what, input logic [23:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic hold(input logic [2:0] sel, input logic [1:0] p);
        reset_n <= 1'b0;
        nvcr_xip_sel <= sel;
        nvcr_proto <= p;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    task automatic ready;
        for (int i = 0; i < 400 && powerup_busy !== 1'b0; i++) begin
            @(posedge clk);
        end
        @(posedge clk);
    endtask
    task automatic boot(input logic [2:0] sel, input logic [1:0] p);
        hold(sel, p);
        ready();
    endtask
    task automatic op(input logic [7:0] k);
        q.delete();
        for (int i = 7; i >= 0; i--) q.push_back({3'h0, k[i]});
        sfxip_host_inst.frame(q);
    endtask
    // fast read: optional command, address, confirmation, 7 more dummies
    task automatic rd(input bit cmd, input int wd, input logic c);
        logic [23:0] a;
        logic [7:0] k;
        a = 24'($urandom);
        k = `SFXIP_CMD_FAST_READ;
        q.delete();
        for (int i = 7; i >= 0 && cmd; i--) q.push_back({3'h0, k[i]});
        for (int i = 24 / wd - 1; i >= 0; i--) begin
            q.push_back(4'((a >> (i * wd)) & ((24'h1 << wd) - 24'h1)));
        end
        q.push_back({3'($urandom), c});
        repeat (7) q.push_back(4'($urandom));
        exp_q.push_back(a);
        sfxip_host_inst.frame(q);
    endtask
    task automatic ones(input int cnt, input logic [3:0] v);
        q.delete();
        repeat (cnt) q.push_back(v);
        sfxip_host_inst.frame(q);
    endtask
    task automatic pin_pulse;
        dev_reset_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        dev_reset_pin_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // expected addresses are noted by the driver, compared here
    always @(posedge clk) begin
        cyc++;
        if (rescue_done === 1'b1) rescue_seen = 1'b1;
        if (cmd_rejected === 1'b1) n_rej = n_rej + 2'h1;
        if (addr_valid === 1'b1 && watch) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("unexpected addr: expected none, seen %h", addr);
            end else begin
                check("addr", addr, exp_q.pop_front());
            end
        end
        // about fourteen times the cycles the sequence needs
        if (cyc == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(50513));
        hold(3'h7, 2'h0);
        op(`SFXIP_CMD_WREN);
        op(`SFXIP_CMD_RD_STATUS);
        check("busy reject", {n_rej, wel, powerup_busy}, 4'h5);
        ready();
        check("idle", {xip_active, vcr_xip_bit, wel, wip, lock_write,
            lock_down, proto}, {6'b010000, SFXIP_PROTO_EXT});
        op(`SFXIP_CMD_WREN);
        check("wren", {wel, cmd_code}, {1'b1, `SFXIP_CMD_WREN});
        rd(1'b1, 1, 1'b0);
        check("xip gated", xip_active, 1'b0);
        basic_xip_variant <= 1'b1;
        rd(1'b1, 1, 1'b0);
        check("xip entry", xip_active, 1'b1);
        rd(1'b0, 1, 1'b0);
        check("xip kept", xip_active, 1'b1);
        pin_pulse();
        check("pin disabled", xip_active, 1'b1);
        rd(1'b0, 1, 1'b1);
        check("xip exit", {xip_active, vcr_xip_bit}, 2'b01);
        rd(1'b1, 1, 1'b0);
        reset_pin_enable <= 1'b1;
        pin_pulse();
        check("pin reset", xip_active, 1'b0);
        for (int i = 0; i < 3; i++) begin
            boot(3'h0, 2'(w[i] - 1));
            check("boot xip", {xip_active, proto}, {1'b1, nvcr_proto});
            rd(1'b0, w[i], 1'b0);
            wip_ext <= 1'b1;
            exp_q.push_back(24'hffffff);
            ones(n[i], 4'hf);
            check("exit", {xip_active, wip, proto},
                {2'b01, nvcr_proto});
            wip_ext <= 1'b0;
        end
        boot(3'h0, 2'h3);
        watch = 1'b0;
        foreach (n[i]) ones(n[i], 4'h9);
        ones(8, 4'h9);
        // let the watcher note the pulse before the flag is read
        @(posedge clk);
        check("rescue", {rescue_seen, xip_active, proto},
            {2'b10, SFXIP_PROTO_EXT});
        tally_and_finish();
    end
endmodule
